/* File: nws_pkg.sv */
// Purpose: shared constants and carrier types for the no-wait burst sram front end
// Assumes: one 100 MHz clock, apb register access, 9-bit byte lanes
// Notes:   register offsets are byte addresses on a 32-bit apb bus
package nws_pkg;

  // apb register map
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;

  // control register fields and reset value
  localparam int          CTRL_INTERLEAVE_BIT = 0;
  localparam int          CTRL_SLEEP_BIT      = 1;
  localparam logic [31:0] CTRL_RESET          = 32'h0000_0001;

  // status register fields
  localparam int STAT_CNT_LSB   = 0;
  localparam int STAT_SEL_BIT   = 2;
  localparam int STAT_WR_BIT    = 3;
  localparam int STAT_DRIVE_BIT = 4;
  localparam int STAT_DESEL_BIT = 5;

  // lane and burst geometry
  localparam int          BYTE_W     = 8;
  localparam int          LANE_W     = 9;
  localparam int          MAX_LANES  = 4;
  localparam int          BURST_W    = 2;
  localparam logic [1:0]  BURST_ZERO = 2'h0;
  localparam logic [1:0]  BURST_STEP = 2'h1;

  // one pipelined command as it moves through the stages
  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [MAX_LANES-1:0] lane_wr;
  } nws_cmd_t;

  localparam nws_cmd_t CMD_IDLE = '{valid: 1'b0, write: 1'b0, lane_wr: 4'h0};

endpackage : nws_pkg

/* File: nws_sram.sv */
// Purpose: synchronous pipelined no-wait burst sram with byte-lane writes
// Assumes: controller runs on pclk; apb slave holds mode and sleep control
// Notes:   read data drives two edges after its command, write data is taken then
`timescale 1ns/10ps
module nws_sram #(
  parameter int ADDR_W = 18,
  parameter int LANES  = 4
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      clock_enable_n,
  input  wire logic                      advance_or_load,
  input  wire logic                      write_n,
  input  wire logic [LANES-1:0]          byte_lane_write_n,
  input  wire logic                      chip_select_n,
  input  wire logic                      chip_select_pair,
  input  wire logic                      chip_select_alt_n,
  input  wire logic                      output_enable_n,
  input  wire logic [ADDR_W-3:0]         address,
  input  wire logic [1:0]                burst_start_bits,
  input  wire logic [LANES*8-1:0]        data_lanes_in,
  output logic      [LANES*8-1:0]        data_lanes_out,
  output logic                           data_lanes_oe,
  input  wire logic [LANES-1:0]          parity_lanes_in,
  output logic      [LANES-1:0]          parity_lanes_out,
  output logic                           parity_lanes_oe
);

  localparam int WORD_W = LANES * nws_pkg::LANE_W;
  localparam int DEPTH  = 1 << ADDR_W;

  // refuse geometries the lane logic cannot serve
  if (!((LANES == 4 && ADDR_W == 18) || (LANES == 2 && ADDR_W == 19))) begin : g_bad_geometry
    $error("nws_sram: only 256K x 36 or 512K x 18 supported");
  end

  // burst address for step n from the start bits, interleaved or linear
  function automatic logic [1:0] burst_addr(input logic [1:0] start,
                                            input logic [1:0] step,
                                            input logic       interleave);
    burst_addr = interleave ? (start ^ step) : 2'(start + step);
  endfunction : burst_addr

  // storage, one 9-bit lane per byte plus parity
  logic [WORD_W-1:0] mem_q [DEPTH];

  // control and pipeline state
  logic [31:0]                   ctrl_q;
  nws_pkg::nws_cmd_t             cmd1_q;
  nws_pkg::nws_cmd_t             cmd2_q;
  logic [ADDR_W-3:0]             hi1_q;
  logic [ADDR_W-3:0]             hi2_q;
  logic [1:0]                    low1_q;
  logic [1:0]                    low2_q;
  logic [1:0]                    start_q;
  logic [nws_pkg::BURST_W-1:0]   cnt_q;
  logic [nws_pkg::BURST_W-1:0]   cnt_d;
  logic                          desel_q;
  logic [LANES*8-1:0]            dout_q;
  logic [LANES-1:0]              pout_q;
  logic                          drive_q;
  logic                          pready_q;
  logic                          pslverr_q;
  logic [31:0]                   prdata_q;
  logic                          run;
  logic                          load;
  logic                          selected;
  logic                          interleave;
  logic                          sleep;
  logic [LANES-1:0]              lane_we;
  logic [ADDR_W-1:0]             act_addr;
  logic [31:0]                   status;

  // decoded inputs
  assign run        = !clock_enable_n;
  assign load       = !advance_or_load;
  assign selected   = !chip_select_n && chip_select_pair && !chip_select_alt_n;
  assign interleave = ctrl_q[nws_pkg::CTRL_INTERLEAVE_BIT];
  assign sleep      = ctrl_q[nws_pkg::CTRL_SLEEP_BIT];
  assign cnt_d      = 2'(cnt_q + nws_pkg::BURST_STEP);
  assign act_addr   = {hi2_q, low2_q};
  assign lane_we    = (run && cmd2_q.valid && cmd2_q.write)
                      ? cmd2_q.lane_wr[LANES-1:0] : '0;

  // first stage: load or advance, burst counter, deselect tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd1_q  <= nws_pkg::CMD_IDLE;
      hi1_q   <= '0;
      low1_q  <= nws_pkg::BURST_ZERO;
      start_q <= nws_pkg::BURST_ZERO;
      cnt_q   <= nws_pkg::BURST_ZERO;
      desel_q <= 1'b1;
    end else if (run) begin
      if (load) begin
        if (selected) begin
          cmd1_q.valid   <= 1'b1;
          cmd1_q.write   <= !write_n;
          cmd1_q.lane_wr <= nws_pkg::MAX_LANES'(~byte_lane_write_n);
          hi1_q          <= address;
          low1_q         <= burst_start_bits;
          start_q        <= burst_start_bits;
          cnt_q          <= nws_pkg::BURST_ZERO;
          desel_q        <= 1'b0;
        end else begin
          cmd1_q.valid <= 1'b0;
          desel_q      <= 1'b1;
        end
      end else if (desel_q) begin
        cmd1_q.valid <= 1'b0;
      end else begin
        cmd1_q.valid   <= 1'b1;
        cmd1_q.lane_wr <= nws_pkg::MAX_LANES'(~byte_lane_write_n);
        cnt_q          <= cnt_d;
        low1_q         <= burst_addr(start_q, cnt_d, interleave);
      end
    end
  end

  // second stage: command waits one edge so data meets it two edges later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd2_q <= nws_pkg::CMD_IDLE;
      hi2_q  <= '0;
      low2_q <= nws_pkg::BURST_ZERO;
    end else if (run) begin
      cmd2_q <= cmd1_q;
      hi2_q  <= hi1_q;
      low2_q <= low1_q;
    end
  end

  // array write per lane, data sampled on the action edge
  always_ff @(posedge pclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i]) begin
        mem_q[act_addr][i*nws_pkg::LANE_W +: nws_pkg::LANE_W] <=
          {parity_lanes_in[i], data_lanes_in[i*nws_pkg::BYTE_W +: nws_pkg::BYTE_W]};
      end
    end
  end

  // read data register, refreshed on the action edge of a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= '0;
      pout_q <= '0;
    end else if (run && cmd2_q.valid && !cmd2_q.write) begin
      for (int i = 0; i < LANES; i++) begin
        dout_q[i*nws_pkg::BYTE_W +: nws_pkg::BYTE_W] <=
          mem_q[act_addr][i*nws_pkg::LANE_W +: nws_pkg::BYTE_W];
        pout_q[i] <= mem_q[act_addr][i*nws_pkg::LANE_W + nws_pkg::BYTE_W];
      end
    end
  end

  // bus drive: selected read in the pipe, output enable on, not asleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= cmd2_q.valid && !cmd2_q.write && !output_enable_n && !sleep
                 && (run || drive_q);
    end
  end

  assign data_lanes_out   = dout_q;
  assign parity_lanes_out = pout_q;
  assign data_lanes_oe    = drive_q;
  assign parity_lanes_oe  = drive_q;

  // status word
  always_comb begin
    status                                   = '0;
    status[nws_pkg::STAT_CNT_LSB +: 2]       = cnt_q;
    status[nws_pkg::STAT_SEL_BIT]            = cmd1_q.valid;
    status[nws_pkg::STAT_WR_BIT]             = cmd1_q.write;
    status[nws_pkg::STAT_DRIVE_BIT]          = drive_q;
    status[nws_pkg::STAT_DESEL_BIT]          = desel_q;
  end

  // apb slave: answer in the first access cycle, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable
                   && paddr != nws_pkg::OFS_CTRL && paddr != nws_pkg::OFS_STATUS;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          nws_pkg::OFS_CTRL:   prdata_q <= ctrl_q;
          nws_pkg::OFS_STATUS: prdata_q <= status;
          default:             prdata_q <= '0;
        endcase
      end
    end
  end

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= nws_pkg::CTRL_RESET;
    end else if (psel && penable && pready_q && pwrite && paddr == nws_pkg::OFS_CTRL) begin
      ctrl_q <= pwdata & 32'h0000_0003;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // steps of a pipelined command
  sequence s_read_issue;
    run && load && selected && write_n;
  endsequence

  sequence s_write_issue;
    run && load && selected && !write_n;
  endsequence

  chk_suspend_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clock_enable_n |=> $stable(cnt_q) && $stable(cmd1_q) && $stable(cmd2_q) && $stable(dout_q))
    else $error("state moved while suspended");

  chk_load_start: assert property (@(posedge pclk) disable iff (!presetn)
    run && load && selected |=> cnt_q == 2'h0 && low1_q == $past(burst_start_bits) && cmd1_q.valid)
    else $error("load did not take start bits");

  chk_burst_step: assert property (@(posedge pclk) disable iff (!presetn)
    run && !load && !desel_q |=> cnt_q == 2'($past(cnt_q) + 2'h1) && cmd1_q.valid)
    else $error("burst counter did not advance");

  chk_interleave_first: assert property (@(posedge pclk) disable iff (!presetn)
    (run && load && selected && interleave) ##1 (run && !load && interleave)
      |=> low1_q == ($past(burst_start_bits, 2) ^ 2'h1))
    else $error("interleaved first step wrong");

  chk_linear_first: assert property (@(posedge pclk) disable iff (!presetn)
    (run && load && selected && !interleave) ##1 (run && !load && !interleave)
      |=> low1_q == 2'($past(burst_start_bits, 2) + 2'h1))
    else $error("linear first step wrong");

  chk_chip_select: assert property (@(posedge pclk) disable iff (!presetn)
    run && load && !selected |=> !cmd1_q.valid && desel_q)
    else $error("deselect load left command valid");

  chk_deselect_cont: assert property (@(posedge pclk) disable iff (!presetn)
    run && !load && desel_q |=> !cmd1_q.valid)
    else $error("continue deselect started a burst");

  chk_read_latency: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_issue ##1 run ##1 (run && !output_enable_n && !sleep) |=> data_lanes_oe)
    else $error("read data not driven two edges later");

  chk_write_lanes: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_issue ##1 run ##1 run |-> lane_we == LANES'(~$past(byte_lane_write_n, 2)))
    else $error("write lanes do not match byte enables");

  chk_no_idle: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_issue ##1 s_write_issue |=> cmd1_q.valid && cmd1_q.write && cmd2_q.valid && !cmd2_q.write)
    else $error("turnaround lost a cycle");

  chk_drive_gate: assert property (@(posedge pclk) disable iff (!presetn)
    data_lanes_oe |-> $past(!output_enable_n) && $past(cmd2_q.valid && !cmd2_q.write))
    else $error("bus driven without selected read");

  chk_sleep_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    sleep |=> !data_lanes_oe)
    else $error("bus driven while asleep");

  chk_no_idle_wr: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_issue ##1 s_read_issue
      |=> cmd1_q.valid && !cmd1_q.write && cmd2_q.valid && cmd2_q.write)
    else $error("write to read turnaround lost a cycle");

endmodule : nws_sram

/* File: nws_ctl_model.sv */
// Purpose: controller model driving the sram memory port
// Assumes: one command per pclk, its data slot two active edges later
// Notes:   released data lanes show the inverse of their last value
`timescale 1ns/10ps
module nws_ctl_model (
  input  wire logic        pclk,
  output logic             ce_n,
  output logic             load_n,
  output logic             we_n,
  output logic [3:0]       lane_wr_n,
  output logic [2:0]       cs,
  output logic             oe_n,
  output logic [15:0]      addr,
  output logic [1:0]       start,
  output logic [31:0]      wdata,
  output logic [3:0]       wpar
);
  logic [37:0] wq[$];

  // idle, selected-looking levels before the first command
  initial begin
    ce_n = 1'h0;
    load_n = 1'h1;
    we_n = 1'h1;
    lane_wr_n = 4'hF;
    cs = 3'h2;
    oe_n = 1'h0;
    addr = 16'h0;
    start = 2'h0;
    wdata = 32'h0;
    wpar = 4'h0;
  end

  // one command per call; fills the data slot of the command two steps back
  task issue(input logic st, input logic ld, input logic wr, input logic [3:0] wen_n,
             input logic [2:0] c, input logic [17:0] a, input logic [35:0] wd,
             input logic ws, input logic hz);
    logic [37:0] w;
    @(posedge pclk);
    ce_n <= st;
    load_n <= ~ld;
    we_n <= ~wr;
    lane_wr_n <= wen_n;
    cs <= c;
    addr <= a[17:2];
    start <= a[1:0];
    if (!st) begin
      wq.push_back({hz, ws, wd});
      if (wq.size() == 3) begin
        w = wq.pop_front();
        oe_n <= w[36] | w[37];
        wdata <= w[36] ? w[31:0] : ~wdata;
        wpar <= w[36] ? w[35:32] : ~wpar;
      end
    end
  endtask : issue
endmodule : nws_ctl_model

/* File: pipelined_no_wait_burst_sram_tb_top.sv */
// Purpose: self-checking bench for the no-wait burst sram front end
// Assumes: apb master and controller model share pclk
// Notes:   expected read data comes from a word model of the array
`timescale 1ns/10ps
module pipelined_no_wait_burst_sram_tb_top;
  typedef struct packed {
    logic        hz;
    logic        rd;
    logic        wr;
    logic [3:0]  wen_n;
    logic [17:0] a;
    logic [35:0] wd;
  } nws_slot_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dout, wdata, r;
  logic [3:0]  pout, lane_wr_n, wpar;
  logic        doe, poe, ce_n, load_n, we_n, oe_n, e, sel, wrb, il, pv, slp;
  logic [2:0]  cs;
  logic [15:0] addr, base;
  logic [1:0]  start, st, cnt;
  logic [35:0] mem[int];
  nws_slot_t   sq[$];
  nws_slot_t   pe;
  int          errors, check_count, cyc, seed;

  nws_ctl_model u_ctl (.pclk(pclk), .ce_n(ce_n), .load_n(load_n), .we_n(we_n),
    .lane_wr_n(lane_wr_n), .cs(cs), .oe_n(oe_n), .addr(addr), .start(start),
    .wdata(wdata), .wpar(wpar));

  nws_sram #(.ADDR_W(18), .LANES(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_enable_n(ce_n), .advance_or_load(load_n),
    .write_n(we_n), .byte_lane_write_n(lane_wr_n), .chip_select_n(cs[2]),
    .chip_select_pair(cs[1]), .chip_select_alt_n(cs[0]), .output_enable_n(oe_n),
    .address(addr), .burst_start_bits(start), .data_lanes_in(wdata), .data_lanes_out(dout),
    .data_lanes_oe(doe), .parity_lanes_in(wpar), .parity_lanes_out(pout),
    .parity_lanes_oe(poe));

  // 100 MHz clock
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task chk(input logic [35:0] seen, input logic [35:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // one memory-port cycle: model the burst, check the slot due now
  task step(input logic stl, input logic ld, input logic wr, input logic [2:0] c,
            input logic [17:0] a, input logic hz, input logic [3:0] wen_n);
    nws_slot_t s;
    s = '0;
    s.hz = hz;
    s.wen_n = wen_n;
    s.wd[31:0] = $random(seed);
    s.wd[35:32] = 4'($random(seed));
    if (!stl) begin
      if (ld) begin
        sel = (c == 3'h2);
        wrb = wr;
        base = a[17:2];
        st = a[1:0];
        cnt = 2'h0;
      end else if (sel) cnt = cnt + 2'h1;
      s.a = {base, il ? st ^ cnt : st + cnt};
      s.rd = sel && !wrb;
      s.wr = sel && wrb;
    end
    u_ctl.issue(stl, ld, wr, wen_n, c, a, s.wd, s.wr, hz);
    @(negedge pclk);
    if (pv) begin
      chk({35'h0, doe}, {35'h0, pe.rd && !pe.hz && !slp}, "data drive");
      chk({35'h0, poe}, {35'h0, pe.rd && !pe.hz && !slp}, "parity drive");
      if (pe.rd && !pe.hz && !slp) chk({pout, dout}, mem[pe.a], "read word");
      pv = 1'h0;
    end
    if (!stl) begin
      sq.push_back(s);
      if (sq.size() == 3) begin
        pe = sq.pop_front();
        pv = 1'h1;
        for (int i = 0; i < 4; i++) begin
          if (pe.wr && !pe.wen_n[i]) begin
            mem[pe.a][8*i+:8] = pe.wd[8*i+:8];
            mem[pe.a][32+i] = pe.wd[32+i];
          end
        end
      end
    end
  endtask : step

  task phase(input int n);
    logic [31:0] v;
    repeat (n) begin
      v = $random(seed);
      step(v[2:0] == 3'h0, v[5:3] < 3'h5, v[6], v[9:8] == 2'h0 ? v[12:10] : 3'h2,
           {14'h0, v[17:14]}, v[20:18] == 3'h0, v[24:21]);
    end
    repeat (3) step(1'h0, 1'h1, 1'h0, 3'h0, 18'h0, 1'h0, 4'hF);
  endtask : phase

  task give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    seed = 32'h857BA075;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {errors, check_count} = '0;
    {sel, wrb, pv, slp, base, st, cnt} = '0;
    il = 1'h1;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, nws_pkg::OFS_CTRL, 32'h0);
    chk({4'h0, r}, {4'h0, nws_pkg::CTRL_RESET}, "ctrl reset");
    apb(1'h0, nws_pkg::OFS_STATUS, 32'h0);
    chk({4'h0, r}, 36'h20, "status reset");
    apb(1'h0, 12'h008, 32'h0);
    chk({3'h0, e, r}, 36'h100000000, "unmapped read");
    for (int w = 0; w < 4; w++) begin
      for (int k = 0; k < 4; k++) step(1'h0, k == 0, 1'h1, 3'h2, {14'h0, 2'(w), 2'h1}, 1'h0, 4'h0);
    end
    phase(80);
    apb(1'h1, nws_pkg::OFS_CTRL, 32'h0);
    apb(1'h0, nws_pkg::OFS_CTRL, 32'h0);
    chk({4'h0, r}, 36'h0, "ctrl linear");
    il = 1'h0;
    phase(80);
    // sleep forces the bus off even for selected reads
    apb(1'h1, nws_pkg::OFS_CTRL, 32'h0000_0002);
    apb(1'h0, nws_pkg::OFS_CTRL, 32'h0);
    chk({4'h0, r}, 36'h2, "ctrl sleep");
    slp = 1'h1;
    phase(20);
    give_verdict();
  end
endmodule : pipelined_no_wait_burst_sram_tb_top
